// ---- logic/rsh_homing.sv ----
// reference search homing controller with apb register access
`timescale 1ns/1ps
`default_nettype none
module rsh_homing
  import rsh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic left_sw,
  input wire logic right_sw,
  input wire logic home_sw,
  input wire logic [31:0] act_pos,
  output logic [31:0] vel_cmd,
  output logic auto_stop_left,
  output logic auto_stop_right,
  output logic pos_load,
  output logic [31:0] pos_load_val,
  output logic enc_clear,
  output logic running
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic [31:0] midpoint(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {a[31], a} + {b[31], b};
    return s[32:1];
  endfunction

  function automatic logic [31:0] velocity(input logic dir, input logic [31:0] v);
    return dir ? v : 32'(-v);
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [2:0] sw_level;
  logic l_s, r_s, h_s;
  logic [7:0] mode_q;
  logic [31:0] search_vel_q, calib_vel_q, sw_dist_q;
  logic [1:0] stop_cfg_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic wr_en;
  logic cmd_start, cmd_stop;
  rsh_state_t state_q;
  logic running_q, done_q, abort_q, bad_mode_q;
  logic [3:0] base;
  logic swap, inv, mode_ok;
  rsh_sw_t target_q;
  logic dir_q, middle_q, leg_q, two_leg_q, inv_q;
  logic [1:0] limit_q;
  logic [31:0] p_a_q, edge1_q, first_ref_q;
  logic [31:0] vel_q, pos_load_val_q;
  logic pos_load_q, enc_clear_q;
  logic tgt_act;
  logic [31:0] edge_now, ref_now;
  logic leg_done;

  // ****************************************************************
  // switch input synchronisation
  // ****************************************************************
  rsh_sync #(.W(3)) rsh_sync_i (
    .pclk(pclk),
    .presetn(presetn),
    .pin({home_sw, right_sw, left_sw}),
    .level(sw_level)
  );

  assign l_s = sw_level[0];
  assign r_s = sw_level[1];
  assign h_s = sw_level[2];

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // zero wait states; read data and error are sampled in the setup cycle
  assign pready = psel & penable;
  assign wr_en = psel & penable & pwrite;
  assign cmd_start = wr_en && paddr == RSH_OFS_CMD
    && pwdata[RSH_CMD_OP_LSB +: 8] == RSH_OPCODE_HOMING
    && pwdata[RSH_CMD_TYPE_LSB +: 2] == RSH_TYPE_START;
  assign cmd_stop = wr_en && paddr == RSH_OFS_CMD
    && pwdata[RSH_CMD_OP_LSB +: 8] == RSH_OPCODE_HOMING
    && pwdata[RSH_CMD_TYPE_LSB +: 2] == RSH_TYPE_STOP;

  // read mux and address check in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      err_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (paddr == RSH_OFS_CMD) begin
        prdata_q <= {31'h0000_0000, running_q};
      end else if (paddr == RSH_OFS_MODE) begin
        prdata_q <= {24'h00_0000, mode_q};
      end else if (paddr == RSH_OFS_SEARCH_VEL) begin
        prdata_q <= search_vel_q;
      end else if (paddr == RSH_OFS_CALIB_VEL) begin
        prdata_q <= calib_vel_q;
      end else if (paddr == RSH_OFS_SW_DIST) begin
        prdata_q <= sw_dist_q;
      end else if (paddr == RSH_OFS_STOP_CFG) begin
        prdata_q <= {30'h0000_0000, stop_cfg_q};
      end else if (paddr == RSH_OFS_STATUS) begin
        prdata_q <= {25'h000_0000, state_q, bad_mode_q, abort_q, done_q, running_q};
      end else if (paddr == RSH_OFS_POS) begin
        prdata_q <= act_pos;
      end else begin
        err_q <= 1'b1;
      end
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pready & err_q;

  // writable settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= RSH_MODE_RST;
      search_vel_q <= RSH_SEARCH_VEL_RST;
      calib_vel_q <= RSH_CALIB_VEL_RST;
      stop_cfg_q <= RSH_STOP_CFG_RST;
    end else if (wr_en) begin
      if (paddr == RSH_OFS_MODE) begin
        mode_q <= pwdata[7:0];
      end else if (paddr == RSH_OFS_SEARCH_VEL) begin
        search_vel_q <= pwdata;
      end else if (paddr == RSH_OFS_CALIB_VEL) begin
        calib_vel_q <= pwdata;
      end else if (paddr == RSH_OFS_STOP_CFG) begin
        stop_cfg_q <= pwdata[1:0];
      end
    end
  end

  // ****************************************************************
  // automatic end switch stops, suppressed during a search
  // ****************************************************************
  assign auto_stop_left = stop_cfg_q[0] & l_s & ~running_q;
  assign auto_stop_right = stop_cfg_q[1] & r_s & ~running_q;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  assign base = mode_q[3:0];
  assign swap = mode_q[RSH_MODE_SWAP_BIT];
  assign inv = mode_q[RSH_MODE_INV_BIT];
  assign mode_ok = mode_q[5:4] == 2'h0 && base != 4'h0 && base <= RSH_M_HOME_NEG
    && (base <= RSH_M_LEFT_MID ? !inv : !swap);

  // active level of the switch searched in the current leg
  always_comb begin
    case (target_q)
      RSH_SW_LEFT: tgt_act = l_s;
      RSH_SW_RIGHT: tgt_act = r_s;
      default: tgt_act = h_s ^ inv_q;
    endcase
  end

  // edge and reference at the re-entry point
  assign edge_now = midpoint(p_a_q, act_pos);
  assign ref_now = middle_q ? midpoint(edge1_q, edge_now) : edge_now;
  assign leg_done = (state_q == RSH_BACK && tgt_act && !middle_q)
    || (state_q == RSH_RET && tgt_act);

  // ****************************************************************
  // search state machine
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RSH_IDLE;
      target_q <= RSH_SW_LEFT;
      dir_q <= 1'b0;
      middle_q <= 1'b0;
      leg_q <= 1'b0;
      two_leg_q <= 1'b0;
      inv_q <= 1'b0;
      limit_q <= 2'h0;
      p_a_q <= 32'h0000_0000;
      edge1_q <= 32'h0000_0000;
      first_ref_q <= 32'h0000_0000;
    end else if (cmd_stop) begin
      state_q <= RSH_IDLE;
    end else begin
      case (state_q)
        RSH_IDLE: begin
          if (cmd_start && mode_ok) begin
            state_q <= RSH_FAST;
            leg_q <= 1'b0;
            inv_q <= inv;
            limit_q <= 2'h0;
            two_leg_q <= base == RSH_M_RL || base == RSH_M_RL_MID;
            middle_q <= base == RSH_M_LEFT_MID || base == RSH_M_HOME_POS
              || base == RSH_M_HOME_NEG;
            case (base)
              RSH_M_LEFT, RSH_M_LEFT_MID: begin
                target_q <= swap ? RSH_SW_RIGHT : RSH_SW_LEFT;
                dir_q <= swap;
              end
              RSH_M_RL, RSH_M_RL_MID: begin
                target_q <= swap ? RSH_SW_LEFT : RSH_SW_RIGHT;
                dir_q <= !swap;
              end
              RSH_M_HOME_NEG_REV: begin
                target_q <= RSH_SW_HOME;
                dir_q <= 1'b0;
                limit_q <= 2'h1;
              end
              RSH_M_HOME_POS_REV: begin
                target_q <= RSH_SW_HOME;
                dir_q <= 1'b1;
                limit_q <= 2'h2;
              end
              RSH_M_HOME_POS: begin
                target_q <= RSH_SW_HOME;
                dir_q <= 1'b1;
              end
              default: begin
                target_q <= RSH_SW_HOME;
                dir_q <= 1'b0;
              end
            endcase
          end
        end
        RSH_FAST: begin
          if (tgt_act) begin
            state_q <= RSH_OFF;
          end else if ((limit_q[0] && l_s && !dir_q) || (limit_q[1] && r_s && dir_q)) begin
            dir_q <= ~dir_q;
          end
        end
        RSH_OFF: begin
          if (!tgt_act) begin
            p_a_q <= act_pos;
            state_q <= RSH_BACK;
          end
        end
        RSH_BACK: begin
          if (tgt_act && middle_q) begin
            edge1_q <= edge_now;
            state_q <= RSH_THRU;
          end
        end
        RSH_THRU: begin
          if (!tgt_act) begin
            p_a_q <= act_pos;
            state_q <= RSH_RET;
          end
        end
        RSH_RET: begin
        end
        default: begin
          state_q <= RSH_IDLE;
        end
      endcase
      if (leg_done) begin
        if (two_leg_q && !leg_q) begin
          first_ref_q <= ref_now;
          leg_q <= 1'b1;
          target_q <= target_q == RSH_SW_RIGHT ? RSH_SW_LEFT : RSH_SW_RIGHT;
          dir_q <= ~dir_q;
          middle_q <= mode_q[3:0] == RSH_M_RL_MID;
          state_q <= RSH_FAST;
        end else begin
          state_q <= RSH_FIN;
        end
      end
    end
  end

  // ****************************************************************
  // velocity command to the ramp generator
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        RSH_FAST: vel_q <= velocity(dir_q, search_vel_q);
        RSH_OFF, RSH_RET: vel_q <= velocity(~dir_q, calib_vel_q);
        RSH_BACK, RSH_THRU: vel_q <= velocity(dir_q, calib_vel_q);
        default: vel_q <= 32'h0000_0000;
      endcase
    end
  end

  assign vel_cmd = vel_q;

  // ****************************************************************
  // zero point, encoder clear and switch distance at completion
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_load_q <= 1'b0;
      enc_clear_q <= 1'b0;
      pos_load_val_q <= 32'h0000_0000;
      sw_dist_q <= 32'h0000_0000;
    end else begin
      pos_load_q <= 1'b0;
      enc_clear_q <= 1'b0;
      if (leg_done && !cmd_stop && !(two_leg_q && !leg_q)) begin
        pos_load_q <= 1'b1;
        pos_load_val_q <= 32'(act_pos - ref_now);
        enc_clear_q <= 1'b1;
        if (two_leg_q) begin
          sw_dist_q <= $signed(ref_now) > $signed(first_ref_q) ? 32'(ref_now - first_ref_q)
            : 32'(first_ref_q - ref_now);
        end
      end
    end
  end

  assign pos_load = pos_load_q;
  assign pos_load_val = pos_load_val_q;
  assign enc_clear = enc_clear_q;

  // ****************************************************************
  // status flags
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      bad_mode_q <= 1'b0;
    end else begin
      if (cmd_stop) begin
        abort_q <= running_q;
        running_q <= 1'b0;
      end else if (state_q == RSH_FIN) begin
        running_q <= 1'b0;
        done_q <= 1'b1;
      end else if (cmd_start && state_q == RSH_IDLE) begin
        running_q <= mode_ok;
        bad_mode_q <= !mode_ok;
        done_q <= 1'b0;
        abort_q <= 1'b0;
      end
    end
  end

  assign running = running_q;

endmodule
`default_nettype wire

// ---- logic/rsh_pkg.sv ----
// shared constants and types of the reference search homing block
package rsh_pkg;

  // ****************************************************************
  // register map (byte offsets on the apb bus)
  // ****************************************************************
  localparam logic [7:0] RSH_OFS_CMD = 8'h00;
  localparam logic [7:0] RSH_OFS_MODE = 8'h04;
  localparam logic [7:0] RSH_OFS_SEARCH_VEL = 8'h08;
  localparam logic [7:0] RSH_OFS_CALIB_VEL = 8'h0C;
  localparam logic [7:0] RSH_OFS_SW_DIST = 8'h10;
  localparam logic [7:0] RSH_OFS_STOP_CFG = 8'h14;
  localparam logic [7:0] RSH_OFS_STATUS = 8'h18;
  localparam logic [7:0] RSH_OFS_POS = 8'h1C;

  // ****************************************************************
  // command field layout and codes
  // ****************************************************************
  localparam int RSH_CMD_OP_LSB = 0;
  localparam int RSH_CMD_TYPE_LSB = 8;
  localparam logic [7:0] RSH_OPCODE_HOMING = 8'h0D;
  localparam logic [1:0] RSH_TYPE_START = 2'h0;
  localparam logic [1:0] RSH_TYPE_STOP = 2'h1;

  // ****************************************************************
  // mode field layout and base modes
  // ****************************************************************
  localparam int RSH_MODE_SWAP_BIT = 6;
  localparam int RSH_MODE_INV_BIT = 7;
  localparam logic [3:0] RSH_M_LEFT = 4'h1;
  localparam logic [3:0] RSH_M_RL = 4'h2;
  localparam logic [3:0] RSH_M_RL_MID = 4'h3;
  localparam logic [3:0] RSH_M_LEFT_MID = 4'h4;
  localparam logic [3:0] RSH_M_HOME_NEG_REV = 4'h5;
  localparam logic [3:0] RSH_M_HOME_POS_REV = 4'h6;
  localparam logic [3:0] RSH_M_HOME_POS = 4'h7;
  localparam logic [3:0] RSH_M_HOME_NEG = 4'h8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RSH_MODE_RST = 8'h01;
  localparam logic [31:0] RSH_SEARCH_VEL_RST = 32'h0000_1000;
  localparam logic [31:0] RSH_CALIB_VEL_RST = 32'h0000_0100;
  localparam logic [1:0] RSH_STOP_CFG_RST = 2'h0;

  // ****************************************************************
  // switch selection and states
  // ****************************************************************
  typedef enum logic [1:0] {
    RSH_SW_LEFT = 2'h0,
    RSH_SW_RIGHT = 2'h1,
    RSH_SW_HOME = 2'h2
  } rsh_sw_t;

  typedef enum logic [2:0] {
    RSH_IDLE = 3'h0,
    RSH_FAST = 3'h1,
    RSH_OFF = 3'h3,
    RSH_BACK = 3'h2,
    RSH_THRU = 3'h6,
    RSH_RET = 3'h7,
    RSH_FIN = 3'h5
  } rsh_state_t;

endpackage

// ---- logic/rsh_sync.sv ----
// three-stage synchroniser with agreement filter for switch pins
`timescale 1ns/1ps
`default_nettype none
module rsh_sync #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // ****************************************************************
  // synchroniser chain; level follows once stages two and three agree
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level = level_q;

endmodule
`default_nettype wire

// ---- bench/rsh_homing_monitor.sv ----
// port level checker of the homing block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module rsh_homing_monitor
  import rsh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] vel_cmd,
  input wire logic auto_stop_left,
  input wire logic auto_stop_right,
  input wire logic pos_load,
  input wire logic enc_clear,
  input wire logic running
);
  logic [31:0] sv_q;
  logic [31:0] cv_q;
  logic [31:0] vprev_q;
  logic cmd_wr;
  logic stop_hit;
  // ****************************************************************
  // helper logic
  // ****************************************************************
  // decode of command writes taken on the bus
  assign cmd_wr = psel && penable && pwrite && (paddr == RSH_OFS_CMD);
  assign stop_hit = cmd_wr && pwdata[7:0] == RSH_OPCODE_HOMING && pwdata[9:8] == RSH_TYPE_STOP;
  // shadow of the speed settings and of the last velocity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv_q <= RSH_SEARCH_VEL_RST;
      cv_q <= RSH_CALIB_VEL_RST;
      vprev_q <= 32'h0;
    end else begin
      vprev_q <= vel_cmd;
      if (psel && penable && pwrite && paddr == RSH_OFS_SEARCH_VEL) sv_q <= pwdata;
      if (psel && penable && pwrite && paddr == RSH_OFS_CALIB_VEL) cv_q <= pwdata;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence s_load;
    pos_load && enc_clear;
  endsequence
  sequence s_leave_search;
    running && (vprev_q == sv_q || vprev_q == -sv_q) && vel_cmd != vprev_q;
  endsequence
  property p_zero_wait;
    psel && penable |-> pready;
  endproperty
  property p_unmapped;
    pready && paddr > RSH_OFS_POS |-> pslverr;
  endproperty
  property p_bad_opcode;
    cmd_wr && pwdata[7:0] != RSH_OPCODE_HOMING && !running |=> !running;
  endproperty
  property p_no_auto_stop;
    running |-> !auto_stop_left && !auto_stop_right;
  endproperty
  property p_search_vel;
    $rose(running) |-> ##[1:3] (vel_cmd == sv_q || vel_cmd == -sv_q);
  endproperty
  property p_calib_vel;
    s_leave_search ##0 (vel_cmd != -vprev_q && vel_cmd != 32'h0)
      |-> vel_cmd == (vprev_q[31] ? cv_q : -cv_q);
  endproperty
  property p_clear_pair;
    (pos_load || enc_clear) |-> s_load ##0 running;
  endproperty
  property p_one_shot;
    s_load |=> !pos_load && !enc_clear && !running;
  endproperty
  property p_run_end;
    $fell(running) |-> $past(pos_load) || $past(stop_hit);
  endproperty
  property p_stop;
    stop_hit |=> !running && !pos_load;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("no zero wait answer");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
  a_bad_opcode: assert property (p_bad_opcode) else $error("wrong opcode started");
  a_no_auto_stop: assert property (p_no_auto_stop) else $error("auto stop while searching");
  a_search_vel: assert property (p_search_vel) else $error("search speed not used");
  a_calib_vel: assert property (p_calib_vel) else $error("calibration speed wrong");
  a_clear_pair: assert property (p_clear_pair) else $error("clear not paired with load");
  a_one_shot: assert property (p_one_shot) else $error("load pulse or run too long");
  a_run_end: assert property (p_run_end) else $error("running fell without cause");
  a_stop: assert property (p_stop) else $error("stop not obeyed");
endmodule
bind rsh_homing rsh_homing_monitor rsh_homing_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .vel_cmd(vel_cmd),
  .auto_stop_left(auto_stop_left), .auto_stop_right(auto_stop_right),
  .pos_load(pos_load), .enc_clear(enc_clear), .running(running)
);
`default_nettype wire

// ---- bench/rsh_axis_model.sv ----
// model of the ramp generator and the three switches of a linear axis
`timescale 1ns/1ps
`default_nettype none
module rsh_axis_model #(
  parameter int L_LO = -130,
  parameter int L_HI = -100,
  parameter int R_LO = 100,
  parameter int R_HI = 130,
  parameter int H_LO = 20,
  parameter int H_HI = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] vel_cmd,
  input wire logic pos_load,
  input wire logic [31:0] pos_load_val,
  input wire logic place,
  input wire logic [31:0] place_val,
  output logic [31:0] act_pos,
  output logic [31:0] origin,
  output logic left_sw,
  output logic right_sw,
  output logic home_sw
);
  logic signed [31:0] abs_q;
  logic signed [31:0] org_q;
  // one microstep a cycle in the commanded direction, slow or fast
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) abs_q <= 32'sh0;
    else if (place) abs_q <= place_val;
    else if (vel_cmd != 32'h0) abs_q <= vel_cmd[31] ? abs_q - 1 : abs_q + 1;
  end
  // a position load shifts the origin so the loaded point reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) org_q <= 32'sh0;
    else if (place) org_q <= 32'sh0;
    else if (pos_load) org_q <= abs_q - $signed(pos_load_val);
  end
  // switch windows in world coordinates, active high
  assign act_pos = abs_q - org_q;
  assign origin = org_q;
  assign left_sw = (abs_q >= L_LO) && (abs_q <= L_HI);
  assign right_sw = (abs_q >= R_LO) && (abs_q <= R_HI);
  assign home_sw = (abs_q >= H_LO) && (abs_q <= H_HI);
endmodule
`default_nettype wire

// ---- bench/rsh_homing_tb.sv ----
// self-checking testbench of the reference search homing block
`timescale 1ns/1ps
`default_nettype none
module rsh_homing_tb
  import rsh_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, place;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, act_pos, vel_cmd, pos_load_val, place_val, origin, rd_s;
  logic left_sw, right_sw, home_sw, auto_stop_left, auto_stop_right;
  logic pos_load, enc_clear, running, er_s;
  int error_cnt = 0;
  int samples_checked = 0;
  localparam logic [31:0] START_CMD = {22'h0, RSH_TYPE_START, RSH_OPCODE_HOMING};
  localparam logic [31:0] STOP_CMD = {22'h0, RSH_TYPE_STOP, RSH_OPCODE_HOMING};
  rsh_homing rsh_homing_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .left_sw(left_sw), .right_sw(right_sw), .home_sw(home_sw),
    .act_pos(act_pos), .vel_cmd(vel_cmd), .auto_stop_left(auto_stop_left),
    .auto_stop_right(auto_stop_right), .pos_load(pos_load), .pos_load_val(pos_load_val),
    .enc_clear(enc_clear), .running(running));
  rsh_axis_model rsh_axis_model_i (.pclk(pclk), .presetn(presetn), .vel_cmd(vel_cmd),
    .pos_load(pos_load), .pos_load_val(pos_load_val), .place(place), .place_val(place_val),
    .act_pos(act_pos), .origin(origin), .left_sw(left_sw), .right_sw(right_sw),
    .home_sw(home_sw));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_s = prdata;
    er_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic near(input logic [31:0] v, input int e);
    int d;
    d = int'($signed(v)) - e;
    return (d <= 8) && (d >= -8);
  endfunction
  // places the slider, runs one search and judges where zero landed
  task automatic run_mode(input logic [7:0] m, input int p0, input int r_exp, input int d_exp);
    int n;
    @(posedge pclk);
    place <= 1'b1;
    place_val <= p0;
    @(posedge pclk);
    place <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b1, RSH_OFS_MODE, {24'h0, m});
    apb(1'b1, RSH_OFS_CMD, START_CMD);
    repeat (10) @(posedge pclk);
    check({31'h0, auto_stop_left}, 32'h0);
    check({31'h0, running}, 32'h1);
    n = 0;
    while (running !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b0, RSH_OFS_STATUS, 32'h0);
    check({30'h0, rd_s[1:0]}, 32'h2);
    check({31'h0, near(origin, r_exp)}, 32'h1);
    if (d_exp >= 0) begin
      apb(1'b0, RSH_OFS_SW_DIST, 32'h0);
      check({31'h0, near(rd_s, d_exp)}, 32'h1);
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_values();
    logic [7:0] ofs [5] = '{RSH_OFS_MODE, RSH_OFS_SEARCH_VEL, RSH_OFS_CALIB_VEL,
      RSH_OFS_STOP_CFG, RSH_OFS_SW_DIST};
    logic [31:0] val [5] = '{32'h1, RSH_SEARCH_VEL_RST, RSH_CALIB_VEL_RST, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      check(rd_s, val[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    check({er_s, rd_s[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_bad_opcode();
    apb(1'b1, RSH_OFS_CMD, {START_CMD[31:8], 8'h0C});
    apb(1'b0, RSH_OFS_STATUS, 32'h0);
    check({31'h0, rd_s[0]}, 32'h0);
  endtask
  task automatic t_auto_stop_idle();
    apb(1'b1, RSH_OFS_STOP_CFG, 32'h3);
    @(posedge pclk);
    place <= 1'b1;
    place_val <= -110;
    @(posedge pclk);
    place <= 1'b0;
    repeat (8) @(posedge pclk);
    check({30'h0, auto_stop_left, auto_stop_right}, 32'h2);
  endtask
  task automatic t_stop_mid();
    apb(1'b1, RSH_OFS_MODE, 32'h1);
    apb(1'b1, RSH_OFS_CMD, START_CMD);
    repeat (20) @(posedge pclk);
    apb(1'b1, RSH_OFS_CMD, STOP_CMD);
    repeat (3) @(posedge pclk);
    apb(1'b0, RSH_OFS_STATUS, 32'h0);
    check({29'h0, rd_s[2:0]}, 32'h4);
    check(vel_cmd, 32'h0);
  endtask
  task automatic t_mode1();
    run_mode(8'd1, 0, -100, -1);
  endtask
  task automatic t_mode2();
    run_mode(8'd2, 0, -100, 200);
  endtask
  task automatic t_mode3();
    run_mode(8'd3, 0, -115, 215);
  endtask
  task automatic t_mode4();
    run_mode(8'd4, 0, -115, -1);
  endtask
  task automatic t_swap();
    run_mode(8'd65, 0, 100, -1);
  endtask
  task automatic t_home_modes();
    run_mode(8'd5, 0, 20, -1);
    run_mode(8'd6, 60, 40, -1);
    run_mode(8'd7, -110, 30, -1);
    run_mode(8'd8, 80, 30, -1);
    run_mode(8'd133, 30, 20, -1);
  endtask
  // ****************************************************************
  // clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    place = 1'b0;
    place_val = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_bad_opcode();
    t_stop_mid();
    t_mode1();
    t_mode2();
    t_mode3();
    t_mode4();
    t_swap();
    t_auto_stop_idle();
    t_home_modes();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
